// >>> nspi_defines.vh
// Function
// - Shared pins stay undriven until the data config register is first written.
// - Serial transmit stream leaves as NRZ data, valid at each tx clock rise.
// - With extended bus option, tx data and loopback pins are user outputs once bus master; tx clock is undriven.
// - Transmit active rises at frame start, falls after the last byte.
// - Internal codec mode divides the system clock to a tx clock and drives it out.
// - External codec mode shifts data on the tx clock from the pin.
// - Memory cycle ends only after sampling sync termination in async bus mode with extended bus option.
// - Loopback indicator is high whenever codec loopback is enabled, unless extended bus option is set.
// - Packet shorten asserts on address filter match or on miss, as programmed.
// - Second config bits 1 and 2 pick shorten mode; undriven until written.
// - Shorten rises after 4th bit of 7th byte, falls one tx clock after carrier.
// - Reject input low for two receive bit clocks rejects the packet.
`ifndef NSPI_DEFINES_VH
`define NSPI_DEFINES_VH

// Register byte addresses
`define NSPI_ADDR_DCR       5'h00
`define NSPI_ADDR_SECOND_CONFIG_REGISTER      5'h04
`define NSPI_ADDR_TXDATA    5'h08
`define NSPI_ADDR_STATUS    5'h0C

// Data config register fields
`define NSPI_DCR_EXTENDED_BUS_OPTION      0
`define NSPI_DCR_EXTCODEC   1
`define NSPI_DCR_BUSMODE    2
`define NSPI_DCR_LOOPBACK   3
`define NSPI_DCR_RESET      4'h0

// Second config register fields
`define NSPI_SECOND_CONFIG_REGISTER_USER2     0
`define NSPI_SECOND_CONFIG_REGISTER_ON_MATCH  1
`define NSPI_SECOND_CONFIG_REGISTER_ON_MISS   2
`define NSPI_SECOND_CONFIG_REGISTER_USER3     3
`define NSPI_SECOND_CONFIG_REGISTER_RESET     4'h0

// Transmit data word: byte plus end-of-frame flag
`define NSPI_TX_LAST        8
`define NSPI_TX_WIDTH       9
`define NSPI_FIFO_DEPTH     32
`define NSPI_FIFO_AW        5

// Timing
`define NSPI_CLK_HZ         10000000
`define NSPI_OSC_HZ         20000000
`define NSPI_TXC_HZ         10000000
`define NSPI_TXC_HALF_RAW   (`NSPI_CLK_HZ / (2 * `NSPI_TXC_HZ))
`define NSPI_TXC_HALF       ((`NSPI_TXC_HALF_RAW > 0) ? `NSPI_TXC_HALF_RAW : 1)
`define NSPI_SHORTEN_BITS   6'h34
`define NSPI_REJECT_BITS    2'h2

`define NSPI_RESP_OKAY      2'h0
`define NSPI_RESP_SLVERR    2'h2

`endif

// >>> nspi_fifo.v
`timescale 1ns/1ps
`default_nettype none
module nspi_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;

	// Extra pointer bit tells full from empty
	assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
	assign out_valid = (wr_q != rd_q);
	assign out_data  = mem[rd_q[AW-1:0]];

	always @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && in_ready) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> nspi_pin_if.v
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "nspi_defines.vh"
module nspi_pin_if (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        bus_master,
	input  wire        mem_cycle_req,
	output reg         mem_cycle_end,
	input  wire        carrier_sense_signal,
	input  wire        rx_bit_valid,
	input  wire        filter_match,
	output reg         rx_reject,
	output reg         tx_active_out,
	output reg         tx_data_o,
	output reg         tx_data_oe,
	output reg         tx_clock_o,
	output reg         tx_clock_oe,
	input  wire        tx_clock_term_i,
	output reg         loopback_indicator,
	output reg         loopback_oe,
	output reg         packet_shorten_out,
	output reg         packet_shorten_oe,
	input  wire        packet_reject_in
);
	////////////////////////////////////////////////////////////////////////////////////////////////
	reg  [3:0] dcr_q;
	reg  [3:0] second_config_register_q;
	reg        dcr_wr_q;
	reg        second_config_register_wr_q;
	reg        master_seen_q;
	reg        aw_pend_q;
	reg        ar_pend_q;
	reg        pin_s1_q;
	reg        pin_s2_q;
	reg        pin_s3_q;
	reg        rej_s1_q;
	reg        rej_s2_q;
	reg        txc_int_q;
	reg        txc_cnt_q;
	reg        busy_q;
	reg        last_q;
	reg  [2:0] bit_q;
	reg  [6:0] sh_q;
	reg        bit_out_q;
	reg        cyc_pend_q;
	reg        carrier_q;
	reg  [5:0] rx_cnt_q;
	reg        off_pend_q;
	reg        shorten_q;
	reg  [1:0] low_cnt_q;
	reg        rej_done_q;

	wire       extended_bus_option    = dcr_q[`NSPI_DCR_EXTENDED_BUS_OPTION];
	wire       external_codec_select      = dcr_q[`NSPI_DCR_EXTCODEC];
	wire       bus_mode_select    = dcr_q[`NSPI_DCR_BUSMODE];
	wire       lbk_en   = dcr_q[`NSPI_DCR_LOOPBACK];
	wire       is_tx_w  = (s_axi_awaddr == `NSPI_ADDR_TXDATA);
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire [8:0] fifo_out_data;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Write channel: both beats taken together; a full FIFO holds back awready
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !aw_pend_q && !s_axi_bvalid
		&& (!is_tx_w || fifo_in_ready);
	wire wr_do = aw_pend_q && s_axi_awvalid && s_axi_wvalid;
	wire tx_push = wr_do && is_tx_w && s_axi_wstrb[0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_pend_q     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `NSPI_RESP_OKAY;
			dcr_q         <= `NSPI_DCR_RESET;
			second_config_register_q        <= `NSPI_SECOND_CONFIG_REGISTER_RESET;
			dcr_wr_q      <= 1'b0;
			second_config_register_wr_q     <= 1'b0;
		end else begin
			aw_pend_q     <= wr_go;
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `NSPI_RESP_OKAY;
				if (s_axi_awaddr == `NSPI_ADDR_DCR) begin
					if (s_axi_wstrb[0]) begin
						dcr_q    <= s_axi_wdata[3:0];
						dcr_wr_q <= 1'b1;
					end
				end else if (s_axi_awaddr == `NSPI_ADDR_SECOND_CONFIG_REGISTER) begin
					if (s_axi_wstrb[0]) begin
						second_config_register_q    <= s_axi_wdata[3:0];
						second_config_register_wr_q <= 1'b1;
					end
				end else if (!is_tx_w) begin
					s_axi_bresp <= `NSPI_RESP_SLVERR;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Read channel
	wire rd_go = s_axi_arvalid && !ar_pend_q && !s_axi_rvalid;
	wire rd_do = ar_pend_q && s_axi_arvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			ar_pend_q     <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `NSPI_RESP_OKAY;
		end else begin
			ar_pend_q     <= rd_go;
			s_axi_arready <= rd_go;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (rd_do) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `NSPI_RESP_OKAY;
				s_axi_rdata  <= 32'h00000000;
				if (s_axi_araddr == `NSPI_ADDR_DCR) begin
					s_axi_rdata[3:0] <= dcr_q;
				end else if (s_axi_araddr == `NSPI_ADDR_SECOND_CONFIG_REGISTER) begin
					s_axi_rdata[3:0] <= second_config_register_q;
				end else if (s_axi_araddr == `NSPI_ADDR_STATUS) begin
					s_axi_rdata[7:0] <= {rej_done_q, shorten_q, master_seen_q, second_config_register_wr_q,
						dcr_wr_q, !fifo_in_ready, !fifo_out_valid, tx_active_out};
				end else if (s_axi_araddr != `NSPI_ADDR_TXDATA) begin
					s_axi_rresp <= `NSPI_RESP_SLVERR;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the first stage feeds only the second
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
			rej_s1_q <= 1'b1;
			rej_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= tx_clock_term_i;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			rej_s1_q <= packet_reject_in;
			rej_s2_q <= rej_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Transmit clock; at this system rate the divider bottoms out at one cycle per half period
	wire txc_tick = (txc_cnt_q == 1'b0);
	wire ext_rise = pin_s2_q && !pin_s3_q;
	wire ext_fall = !pin_s2_q && pin_s3_q;
	wire tx_rise  = external_codec_select ? ext_rise : (txc_tick && !txc_int_q);
	wire tx_fall  = external_codec_select ? ext_fall : (txc_tick && txc_int_q);

	always @(posedge aclk) begin
		if (!aresetn) begin
			txc_int_q <= 1'b0;
			txc_cnt_q <= 1'b0;
		end else begin
			if (txc_tick) begin
				txc_int_q <= !txc_int_q;
				txc_cnt_q <= (`NSPI_TXC_HALF > 1) ? 1'b1 : 1'b0;
			end else begin
				txc_cnt_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Serializer: changes on the falling edge so data is stable at the rise
	wire need_byte = !busy_q || (bit_q == 3'h7 && !last_q);
	wire fifo_pop  = tx_fall && need_byte;

	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_q        <= 1'b0;
			last_q        <= 1'b0;
			bit_q         <= 3'h0;
			sh_q          <= 7'h00;
			bit_out_q     <= 1'b0;
			tx_active_out <= 1'b0;
		end else if (tx_fall) begin
			if (busy_q && bit_q != 3'h7) begin
				bit_out_q <= sh_q[0];
				sh_q      <= {1'b0, sh_q[6:1]};
				bit_q     <= bit_q + 3'h1;
			end else if (need_byte && fifo_out_valid) begin
				bit_out_q     <= fifo_out_data[0];
				sh_q          <= fifo_out_data[7:1];
				last_q        <= fifo_out_data[`NSPI_TX_LAST];
				bit_q         <= 3'h0;
				busy_q        <= 1'b1;
				tx_active_out <= 1'b1;
			end else begin
				// Last byte done, or the FIFO ran dry mid-frame
				busy_q        <= 1'b0;
				bit_out_q     <= 1'b0;
				tx_active_out <= 1'b0;
			end
		end
	end

	nspi_fifo #(
		.WIDTH (`NSPI_TX_WIDTH),
		.DEPTH (`NSPI_FIFO_DEPTH),
		.AW    (`NSPI_FIFO_AW)
	) u_fifo (
		.clk       (aclk),
		.rst_n     (aresetn),
		.in_valid  (tx_push),
		.in_ready  (fifo_in_ready),
		.in_data   (s_axi_wdata[8:0]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Bus master memory cycles
	wire term_ok = !(extended_bus_option && bus_mode_select) || pin_s2_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			master_seen_q <= 1'b0;
			cyc_pend_q    <= 1'b0;
			mem_cycle_end <= 1'b0;
		end else begin
			if (bus_master) begin
				master_seen_q <= 1'b1;
			end
			mem_cycle_end <= 1'b0;
			if (mem_cycle_req) begin
				cyc_pend_q <= 1'b1;
			end else if (cyc_pend_q && bus_master && term_ok) begin
				cyc_pend_q    <= 1'b0;
				mem_cycle_end <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Receive side: shorten timing and packet reject
	wire car_rise = carrier_sense_signal && !carrier_q;
	wire car_fall = !carrier_sense_signal && carrier_q;
	wire hit_bit  = rx_bit_valid && carrier_sense_signal && (rx_cnt_q == `NSPI_SHORTEN_BITS - 6'h01);

	always @(posedge aclk) begin
		if (!aresetn) begin
			carrier_q  <= 1'b0;
			rx_cnt_q   <= 6'h00;
			off_pend_q <= 1'b0;
			shorten_q  <= 1'b0;
			low_cnt_q  <= 2'h0;
			rej_done_q <= 1'b0;
			rx_reject  <= 1'b0;
		end else begin
			carrier_q <= carrier_sense_signal;
			rx_reject <= 1'b0;
			if (car_rise) begin
				rx_cnt_q   <= 6'h00;
				low_cnt_q  <= 2'h0;
				rej_done_q <= 1'b0;
			end else if (rx_bit_valid && carrier_sense_signal && rx_cnt_q != `NSPI_SHORTEN_BITS) begin
				rx_cnt_q <= rx_cnt_q + 6'h01;
			end
			if (hit_bit) begin
				shorten_q <= (second_config_register_q[`NSPI_SECOND_CONFIG_REGISTER_ON_MATCH] && filter_match)
					|| (second_config_register_q[`NSPI_SECOND_CONFIG_REGISTER_ON_MISS] && !filter_match);
			end else if (off_pend_q && tx_rise) begin
				shorten_q <= 1'b0;
			end
			if (car_fall) begin
				off_pend_q <= 1'b1;
			end else if (tx_rise || car_rise) begin
				off_pend_q <= 1'b0;
			end
			if (rx_bit_valid && carrier_sense_signal && !rej_done_q) begin
				if (rej_s2_q) begin
					low_cnt_q <= 2'h0;
				end else if (low_cnt_q == `NSPI_REJECT_BITS - 2'h1) begin
					rej_done_q <= 1'b1;
					rx_reject  <= 1'b1;
				end else begin
					low_cnt_q <= low_cnt_q + 2'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Pin drivers; enables off until the relevant config write
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_data_o          <= 1'b0;
			tx_data_oe         <= 1'b0;
			tx_clock_o         <= 1'b0;
			tx_clock_oe        <= 1'b0;
			loopback_indicator <= 1'b0;
			loopback_oe        <= 1'b0;
			packet_shorten_out <= 1'b0;
			packet_shorten_oe  <= 1'b0;
		end else begin
			tx_data_o          <= extended_bus_option ? second_config_register_q[`NSPI_SECOND_CONFIG_REGISTER_USER3] : bit_out_q;
			tx_data_oe         <= dcr_wr_q && (!extended_bus_option || master_seen_q);
			tx_clock_o         <= txc_int_q;
			tx_clock_oe        <= dcr_wr_q && !extended_bus_option && !external_codec_select;
			loopback_indicator <= extended_bus_option ? second_config_register_q[`NSPI_SECOND_CONFIG_REGISTER_USER2] : lbk_en;
			loopback_oe        <= dcr_wr_q && (!extended_bus_option || master_seen_q);
			packet_shorten_out <= shorten_q;
			packet_shorten_oe  <= second_config_register_wr_q;
		end
	end
endmodule
`default_nettype wire

// >>> nspi_pin_if_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "nspi_defines.vh"
module nspi_pin_if_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [4:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        bus_master,
	input wire logic        mem_cycle_end,
	input wire logic        tx_data_oe,
	input wire logic        tx_clock_o,
	input wire logic        tx_clock_oe,
	input wire logic        loopback_oe,
	input wire logic        packet_shorten_oe
);
	logic dcr_seen_q;
	logic second_config_register_seen_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Only a taken write with byte 0 enabled counts as a config write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dcr_seen_q <= 1'h0;
			second_config_register_seen_q <= 1'h0;
		end else if (s_axi_awvalid && s_axi_awready && s_axi_wstrb[0]) begin
			if (s_axi_awaddr == `NSPI_ADDR_DCR)
				dcr_seen_q <= 1'h1;
			if (s_axi_awaddr == `NSPI_ADDR_SECOND_CONFIG_REGISTER)
				second_config_register_seen_q <= 1'h1;
		end
	end
	sequence s_wr_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence s_clk_on;
		tx_clock_oe ##1 tx_clock_oe;
	endsequence
	chk_pins_undriven: assert property (!dcr_seen_q |-> !tx_data_oe && !tx_clock_oe && !loopback_oe)
		else $error("shared pin driven before config write");
	chk_shorten_undriven: assert property (!second_config_register_seen_q |-> !packet_shorten_oe)
		else $error("shorten pin driven before second config write");
	chk_write_pair: assert property (s_axi_awready |-> s_axi_wready)
		else $error("address and data not taken together");
	chk_write_resp: assert property (s_wr_taken |=> s_axi_bvalid)
		else $error("write response late");
	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_read_resp: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_end_master: assert property (mem_cycle_end |-> bus_master || $past(bus_master))
		else $error("memory cycle ended without bus ownership");
	chk_end_pulse: assert property (mem_cycle_end |=> !mem_cycle_end)
		else $error("memory cycle end longer than one cycle");
	chk_txclk_toggle: assert property (s_clk_on |-> tx_clock_o != $past(tx_clock_o))
		else $error("internal tx clock stalled");
endmodule
bind nspi_pin_if nspi_pin_if_assertions chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wstrb, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .bus_master, .mem_cycle_end, .tx_data_oe, .tx_clock_o, .tx_clock_oe,
	.loopback_oe, .packet_shorten_oe);
`default_nettype wire

// >>> nspi_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module nspi_codec_model (
	input  wire logic ext_mode,
	input  wire logic run,
	input  wire logic tx_clock_o,
	input  wire logic tx_data_o,
	input  wire logic tx_active_out,
	output var  logic ext_clk
);
	logic [7:0] sh_q = 8'h00;
	int         nbit = 0;
	logic [7:0] got[$];
	wire        sclk = ext_mode ? ext_clk : tx_clock_o;
	// Internal mode moves active on the edge that raises the clock pin, data on the next one; look just before it
	wire #5     data_d = tx_data_o;
	wire #5     act_d  = tx_active_out;
	// Clock runs only while a frame is wanted, so the fifo can be filled first
	initial begin
		ext_clk = 1'h0;
		forever begin
			wait (run);
			#137;
			while (run)
				#400 ext_clk = ~ext_clk;
			ext_clk = 1'h0;
		end
	end
	// Bits arrive LSB first, sampled at each tx clock rise
	always @(posedge sclk) begin
		if (act_d) begin
			sh_q = {data_d, sh_q[7:1]};
			nbit = nbit + 1;
			if (nbit == 8) begin
				got.push_back(sh_q);
				nbit = 0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb_nspi_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
module tb_nspi_pin_if;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	logic        bus_master, mem_cycle_req, carrier_sense_signal, rx_bit_valid, filter_match;
	logic        packet_reject_in, term, run, ext_mode;
	wire         mem_cycle_end, rx_reject, tx_active_out, tx_data_o, tx_data_oe, tx_clock_o, tx_clock_oe;
	wire         loopback_indicator, loopback_oe, packet_shorten_out, packet_shorten_oe, ext_clk;
	wire         tx_clock_term_i = ext_mode ? ext_clk : term;
	int          failures = 0, compares = 0, rejects = 0, ends = 0;
	nspi_pin_if dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_master, .mem_cycle_req,
		.mem_cycle_end, .carrier_sense_signal, .rx_bit_valid, .filter_match, .rx_reject, .tx_active_out,
		.tx_data_o, .tx_data_oe, .tx_clock_o, .tx_clock_oe, .tx_clock_term_i, .loopback_indicator,
		.loopback_oe, .packet_shorten_out, .packet_shorten_oe, .packet_reject_in);
	nspi_codec_model partner (.ext_mode, .run, .tx_clock_o, .tx_data_o, .tx_active_out, .ext_clk);
	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		rejects <= rejects + (rx_reject === 1'h1);
		ends <= ends + (mem_cycle_end === 1'h1);
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (s_axi_awready !== 1'h1);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		while (s_axi_bvalid !== 1'h1) @(posedge aclk);
		s_axi_bready <= 1'h0;
		check("bresp", er, s_axi_bresp);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		while (s_axi_rvalid !== 1'h1) @(posedge aclk);
		s_axi_rready <= 1'h0;
		check("rdata", exp, s_axi_rdata);
		check("rresp", er, s_axi_rresp);
	endtask
	task automatic bits(input int n);
		repeat (n) begin
			@(posedge aclk);
			rx_bit_valid <= 1'h1;
			@(posedge aclk);
			rx_bit_valid <= 1'h0;
		end
	endtask
	task automatic frame(input int n, input int lim);
		partner.got.delete();
		for (int i = 0; i < n; i++)
			wr(5'h08, 32'h100 * (i == n - 1) + i * 7 + 3, 2'h0);
		for (int i = 0; i < lim && tx_active_out !== 1'h1; i++) @(posedge aclk);
		check("tx active", 1, tx_active_out);
		for (int i = 0; i < lim && tx_active_out !== 1'h0; i++) @(posedge aclk);
		check("byte count", n, partner.got.size());
		for (int i = 0; i < n; i++)
			check("tx byte", i * 7 + 3, partner.got[i]);
	endtask
	task automatic shorten_case(input logic [3:0] mode, input logic hit);
		wr(5'h04, {28'h0, mode}, 2'h0);
		filter_match <= hit;
		carrier_sense_signal <= 1'h1;
		bits(51);
		settle(3);
		check("shorten early", 0, packet_shorten_out);
		bits(1);
		settle(3);
		check("shorten", {mode[1] & hit | mode[2] & ~hit, 1'h1}, {packet_shorten_out, packet_shorten_oe});
		carrier_sense_signal <= 1'h0;
		settle(6);
		check("shorten end", 0, packet_shorten_out);
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {10'h000, 32'h0, 4'hF};
		{bus_master, mem_cycle_req, carrier_sense_signal, rx_bit_valid, filter_match} = 5'h00;
		// Reject pin idles high: it is active low
		{packet_reject_in, term, run, ext_mode} = 4'h8;
		settle(2);
		aresetn <= 1'h1;
		settle(1);
		check("oe at reset", 0, {tx_data_oe, tx_clock_oe, loopback_oe, packet_shorten_oe});
		wr(5'h0C, 32'h1, 2'h2);
		rd(5'h10, 0, 2'h2);
		rd(5'h0C, 32'h02, 2'h0);
		wr(5'h00, 32'h8, 2'h0);
		settle(3);
		check("loopback", 3, {loopback_indicator, loopback_oe});
		check("tx clock oe", 1, tx_clock_oe);
		frame(2, 200);
		wr(5'h00, 32'h0, 2'h0);
		settle(3);
		check("loopback off", 1, {loopback_indicator, loopback_oe});
		ext_mode <= 1'h1;
		wr(5'h00, 32'h2, 2'h0);
		settle(3);
		check("ext clock oe", 0, tx_clock_oe);
		fork
			frame(32, 3000);
			begin
				settle(400);
				rd(5'h0C, 32'h0C, 2'h0);
				run <= 1'h1;
			end
		join
		run <= 1'h0;
		ext_mode <= 1'h0;
		wr(5'h00, 32'h0, 2'h0);
		for (int k = 0; k < 4; k++)
			shorten_case(4'h2 << k[1], k[0]);
		carrier_sense_signal <= 1'h1;
		packet_reject_in <= 1'h0;
		settle(3);
		bits(1);
		packet_reject_in <= 1'h1;
		settle(3);
		bits(3);
		check("single bit reject", 0, rejects);
		packet_reject_in <= 1'h0;
		settle(3);
		bits(2);
		settle(3);
		check("reject", 1, rejects);
		carrier_sense_signal <= 1'h0;
		packet_reject_in <= 1'h1;
		wr(5'h00, 32'h5, 2'h0);
		wr(5'h04, 32'h9, 2'h0);
		settle(3);
		check("user oe early", 0, {tx_data_oe, loopback_oe});
		bus_master <= 1'h1;
		settle(3);
		check("user outputs", 4'hF, {tx_data_oe, tx_data_o, loopback_oe, loopback_indicator});
		mem_cycle_req <= 1'h1;
		settle(1);
		mem_cycle_req <= 1'h0;
		settle(6);
		check("end held", 0, ends);
		term <= 1'h1;
		settle(8);
		check("end", 1, ends);
		wr(5'h04, 32'h0, 2'h0);
		settle(3);
		check("user low", 0, {tx_data_o, loopback_indicator});
		s_axi_wstrb <= 4'h0;
		wr(5'h04, 32'h9, 2'h0);
		s_axi_wstrb <= 4'hF;
		settle(3);
		check("masked write", 0, {tx_data_o, loopback_indicator});
		finish_test;
	end
	// Longest path is the 32-byte frame at the slow link clock
	initial begin
		#(100 * 20000);
		failures++;
		finish_test;
	end
endmodule
`default_nettype wire
